// [include/otg_line_regs_pkg.sv]
package otg_line_regs_pkg;

  // ==========================================================================
  // register addresses
  localparam logic [7:0] ADDR_CTRL2_SET   = 8'h06;
  localparam logic [7:0] ADDR_CTRL2_CLEAR = 8'h07;
  localparam logic [7:0] ADDR_SOURCE      = 8'h08;
  localparam logic [7:0] ADDR_LATCH_SET   = 8'h0A;
  localparam logic [7:0] ADDR_LATCH_CLEAR = 8'h0B;
  localparam logic [7:0] ADDR_FALL_SET    = 8'h0C;
  localparam logic [7:0] ADDR_FALL_CLEAR  = 8'h0D;
  localparam logic [7:0] ADDR_RISE_SET    = 8'h0E;
  localparam logic [7:0] ADDR_RISE_CLEAR  = 8'h0F;

  // ==========================================================================
  // field positions of the line and bus power control register
  localparam int BIT_VBUS_DRIVE     = 5;
  localparam int BIT_VBUS_DISCHARGE = 6;
  localparam int BIT_VBUS_CHARGE    = 7;

  // ==========================================================================
  // field positions of the interrupt condition register
  localparam int SRC_VBUS_VALID    = 0;
  localparam int SRC_SESSION_VALID = 1;
  localparam int SRC_PLUS_HIGH     = 2;
  localparam int SRC_IDENT_GROUND  = 3;
  localparam int SRC_MINUS_HIGH    = 4;
  localparam int SRC_IDENT_OPEN    = 5;
  localparam int SRC_RECONNECT     = 6;
  localparam int SRC_SESSION_OVER  = 7;

  // ==========================================================================
  // reset values and widths
  localparam logic [7:0] CTRL2_RESET  = 8'h0C;
  localparam logic [7:0] LATCH_RESET  = 8'h00;
  localparam logic [7:0] ENABLE_RESET = 8'h00;
  localparam logic [7:0] READ_ZERO    = 8'h00;
  localparam int         COMP_COUNT   = 9;
  localparam logic [1:0] SYNC_FILL    = 2'h3;
  localparam logic [1:0] FILL_STEP    = 2'h1;

  // ==========================================================================
  // carriers
  typedef struct packed {
    logic vbus_charge;
    logic vbus_discharge;
    logic vbus_drive;
    logic ident_line_ground;
    logic minus_line_pull_low;
    logic plus_line_pull_low;
    logic minus_line_pull_high;
    logic plus_line_pull_high;
  } ctrl2_t;

  typedef struct packed {
    logic line_rise_threshold;
    logic session_end;
    logic reconnect_done;
    logic ident_open;
    logic minus_line_high_seen;
    logic ident_grounded;
    logic plus_line_high_seen;
    logic session_valid;
    logic vbus_valid;
  } comp_t;

  typedef struct packed {
    logic       write;
    logic       read;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

endpackage

// [hdl/cond_sync.sv]
`timescale 1ns/100ps
module cond_sync
  import otg_line_regs_pkg::*;
(
  // clock and reset
  input  logic  clk,
  input  logic  nrst,
  input  logic  ce,
  // conditions
  input  comp_t raw,
  output comp_t stable
);

  typedef struct packed {
    comp_t meta;
    comp_t held;
  } sync_state_t;

  sync_state_t s;
  sync_state_t next_s;

  // ==========================================================================
  // two stages; the first is seen only by the second
  always_comb
  begin
    next_s      = s;
    next_s.meta = raw;
    next_s.held = s.meta;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      s <= '0;
    else if (ce)
      s <= next_s;
  end

  assign stable = s.held;

endmodule

// [hdl/otg_line_regs.sv]
`timescale 1ns/100ps
// Function
// - line and bus power control register uses a set and a clear address
// - bits 0 and 1 switch pull-ups on plus and minus lines, reset 0
// - bits 2 and 3 switch pull-downs on plus and minus lines, reset 1
// - bit 4 grounds the ident line, reset 0
// - bit 5 drives VBUS through low impedance, reset 0
// - bits 6 and 7 connect VBUS discharge and charge resistors, reset 0
// - drive, discharge and charge bits are mutually exclusive
// - setting drive forces discharge and charge to zero
// - several VBUS bits in one set write: drive over discharge over charge
// - ones written to a set address set bits; zeros change nothing
// - ones written to a clear address clear bits
// - read-only condition register shows present levels; writes ignored
// - condition bits 0 and 1 show VBUS valid and session valid
// - condition bits 2 and 4 show plus and minus line high
// - condition bit 3 shows ident grounded, bit 5 ident open
// - condition bit 6 shows reconnect done while reconnect enable is set
// - reconnect enable input gates the automatic reconnection condition
// - condition bit 7 selects session over or line rise by select input
// - latch records fired conditions; fall and rise enables pick edges
// - latch and both enable registers use set and clear addresses
// - a latch bit sets on an enabled edge of its condition
module otg_line_regs
  import otg_line_regs_pkg::*;
(
  // clock and reset
  input  logic       CLK,
  input  logic       NRST,
  input  logic       CE,
  // register port from the serial engine
  input  reg_req_t   REG,
  output logic [7:0] RDATA,
  // bits held in other registers
  input  logic       RECONNECT_ENABLE,
  input  logic       SOURCE_SELECT,
  // analog comparators and reconnect status
  input  comp_t      COMP,
  // controls to the analog switches, and the event latch
  output ctrl2_t     LINE_CTRL,
  output logic [7:0] LATCH
);

  // ==========================================================================
  // state
  typedef struct packed {
    ctrl2_t     ctrl2;
    logic [7:0] latch;
    logic [7:0] en_fall;
    logic [7:0] en_rise;
    logic [7:0] prev_src;
    logic [1:0] fill;
    logic [7:0] rdata;
  } state_t;

  state_t     s;
  state_t     next_s;
  comp_t      synced;
  logic [7:0] src;
  logic [7:0] rise_hits;
  logic [7:0] fall_hits;
  logic       primed;

  // ==========================================================================
  // condition synchroniser
  cond_sync cond_sync_inst
  (
    .clk    (CLK),
    .nrst   (NRST),
    .ce     (CE),
    .raw    (COMP),
    .stable (synced)
  );

  // ==========================================================================
  // present condition levels
  always_comb
  begin
    src                    = READ_ZERO;
    src[SRC_VBUS_VALID]    = synced.vbus_valid;
    src[SRC_SESSION_VALID] = synced.session_valid;
    src[SRC_PLUS_HIGH]     = synced.plus_line_high_seen;
    src[SRC_IDENT_GROUND]  = synced.ident_grounded;
    src[SRC_MINUS_HIGH]    = synced.minus_line_high_seen;
    src[SRC_IDENT_OPEN]    = synced.ident_open;
    src[SRC_RECONNECT]     = RECONNECT_ENABLE & synced.reconnect_done;
    src[SRC_SESSION_OVER]  = SOURCE_SELECT ? synced.line_rise_threshold
                                           : synced.session_end;
  end

  // ==========================================================================
  // edge detection
  // edges are held off until the synchroniser has filled after reset,
  // so a condition already high at power-up raises no event
  assign primed    = (s.fill == SYNC_FILL);
  assign rise_hits = primed ? (src & ~s.prev_src & s.en_rise) : READ_ZERO;
  assign fall_hits = primed ? (~src & s.prev_src & s.en_fall) : READ_ZERO;

  // ==========================================================================
  // set write with VBUS interlock
  function automatic logic [7:0] ctrl2_set(input logic [7:0] cur,
                                          input logic [7:0] w);
    logic [7:0] r;
    r = cur | w;
    if (w[BIT_VBUS_DRIVE])
    begin
      r[BIT_VBUS_DISCHARGE] = 1'b0;
      r[BIT_VBUS_CHARGE]    = 1'b0;
    end
    else if (w[BIT_VBUS_DISCHARGE])
    begin
      r[BIT_VBUS_DRIVE]  = 1'b0;
      r[BIT_VBUS_CHARGE] = 1'b0;
    end
    else if (w[BIT_VBUS_CHARGE])
    begin
      r[BIT_VBUS_DRIVE]     = 1'b0;
      r[BIT_VBUS_DISCHARGE] = 1'b0;
    end
    return r;
  endfunction

  // ==========================================================================
  // next state
  always_comb
  begin
    next_s          = s;
    next_s.prev_src = src;
    if (!primed)
      next_s.fill = s.fill + FILL_STEP;
    if (REG.write)
    begin
      // the condition register address falls through: writes do nothing
      if (REG.addr == ADDR_CTRL2_SET)
        next_s.ctrl2 = ctrl2_set(s.ctrl2, REG.wdata);
      else if (REG.addr == ADDR_CTRL2_CLEAR)
        next_s.ctrl2 = s.ctrl2 & ~REG.wdata;
      else if (REG.addr == ADDR_LATCH_SET)
        next_s.latch = s.latch | REG.wdata;
      else if (REG.addr == ADDR_LATCH_CLEAR)
        next_s.latch = s.latch & ~REG.wdata;
      else if (REG.addr == ADDR_FALL_SET)
        next_s.en_fall = s.en_fall | REG.wdata;
      else if (REG.addr == ADDR_FALL_CLEAR)
        next_s.en_fall = s.en_fall & ~REG.wdata;
      else if (REG.addr == ADDR_RISE_SET)
        next_s.en_rise = s.en_rise | REG.wdata;
      else if (REG.addr == ADDR_RISE_CLEAR)
        next_s.en_rise = s.en_rise & ~REG.wdata;
    end
    // an event in the same cycle as a clear still lands
    next_s.latch = next_s.latch | rise_hits | fall_hits;
    if (REG.read)
    begin
      if (REG.addr == ADDR_CTRL2_SET || REG.addr == ADDR_CTRL2_CLEAR)
        next_s.rdata = s.ctrl2;
      else if (REG.addr == ADDR_SOURCE)
        next_s.rdata = src;
      else if (REG.addr == ADDR_LATCH_SET || REG.addr == ADDR_LATCH_CLEAR)
        next_s.rdata = s.latch;
      else if (REG.addr == ADDR_FALL_SET || REG.addr == ADDR_FALL_CLEAR)
        next_s.rdata = s.en_fall;
      else if (REG.addr == ADDR_RISE_SET || REG.addr == ADDR_RISE_CLEAR)
        next_s.rdata = s.en_rise;
      else
        next_s.rdata = READ_ZERO;
    end
  end

  // ==========================================================================
  // state register
  always_ff @(posedge CLK or negedge NRST)
  begin
    if (!NRST)
    begin
      s          <= '0;
      s.ctrl2    <= CTRL2_RESET;
      s.latch    <= LATCH_RESET;
      s.en_fall  <= ENABLE_RESET;
      s.en_rise  <= ENABLE_RESET;
    end
    else if (CE)
      s <= next_s;
  end

  assign RDATA     = s.rdata;
  assign LINE_CTRL = s.ctrl2;
  assign LATCH     = s.latch;

  // ==========================================================================
  // checks
  a_vbus_one_hot: assert property (
    @(posedge CLK) disable iff (!NRST)
    $onehot0({s.ctrl2.vbus_drive, s.ctrl2.vbus_discharge,
              s.ctrl2.vbus_charge}))
    else $error("more than one VBUS function active");

  a_drive_wins: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_SET
     && REG.wdata[BIT_VBUS_DRIVE])
    |=> (s.ctrl2.vbus_drive && !s.ctrl2.vbus_discharge
         && !s.ctrl2.vbus_charge))
    else $error("drive set did not clear discharge and charge");

  a_discharge_wins: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_SET
     && !REG.wdata[BIT_VBUS_DRIVE] && REG.wdata[BIT_VBUS_DISCHARGE])
    |=> (!s.ctrl2.vbus_drive && s.ctrl2.vbus_discharge
         && !s.ctrl2.vbus_charge))
    else $error("discharge priority broken");

  a_set_low_bits: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_SET)
    |=> ((s.ctrl2[4:0] & $past(REG.wdata[4:0])) == $past(REG.wdata[4:0]))
        && ((s.ctrl2[4:0] & ~$past(REG.wdata[4:0]))
            == ($past(s.ctrl2[4:0]) & ~$past(REG.wdata[4:0]))))
    else $error("set write did not set or disturbed other bits");

  a_clear_bits: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_CLEAR)
    |=> (s.ctrl2 == ($past(s.ctrl2) & ~$past(REG.wdata))))
    else $error("clear write wrong");

  a_source_no_write: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_SOURCE)
    |=> ($stable(s.ctrl2) && $stable(s.en_fall) && $stable(s.en_rise)))
    else $error("write to condition register changed state");

  a_source_read: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.read && REG.addr == ADDR_SOURCE)
    |=> (RDATA == $past(src)))
    else $error("condition read returned wrong value");

  a_reconnect_gate: assert property (
    @(posedge CLK) disable iff (!NRST)
    !RECONNECT_ENABLE |-> !src[SRC_RECONNECT])
    else $error("reconnect condition shown while disabled");

  a_rise_latched: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && primed && ((src & ~s.prev_src & s.en_rise) != READ_ZERO))
    |=> ((s.latch & $past(src & ~s.prev_src & s.en_rise))
         == $past(src & ~s.prev_src & s.en_rise)))
    else $error("enabled rising edge not latched");

  a_no_edge_hold: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && !REG.write && rise_hits == READ_ZERO && fall_hits == READ_ZERO)
    |=> $stable(s.latch))
    else $error("latch changed without cause");

  a_sync_delay: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && COMP.vbus_valid) [*3] |-> src[SRC_VBUS_VALID])
    else $error("condition not through synchroniser in two cycles");

  a_charge_wins: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_SET
     && !REG.wdata[BIT_VBUS_DRIVE] && !REG.wdata[BIT_VBUS_DISCHARGE]
     && REG.wdata[BIT_VBUS_CHARGE])
    |=> (!s.ctrl2.vbus_drive && !s.ctrl2.vbus_discharge
         && s.ctrl2.vbus_charge))
    else $error("charge priority broken");

  a_vbus_untouched: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_CTRL2_SET
     && !REG.wdata[BIT_VBUS_DRIVE] && !REG.wdata[BIT_VBUS_DISCHARGE]
     && !REG.wdata[BIT_VBUS_CHARGE])
    |=> $stable({s.ctrl2.vbus_drive, s.ctrl2.vbus_discharge,
                 s.ctrl2.vbus_charge}))
    else $error("set write without VBUS bits moved a VBUS bit");

  a_read_ctrl: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.read
     && (REG.addr == ADDR_CTRL2_SET || REG.addr == ADDR_CTRL2_CLEAR))
    |=> (RDATA == $past(s.ctrl2)))
    else $error("control read returned wrong value");

  a_rdata_hold: assert property (
    @(posedge CLK) disable iff (!NRST)
    !(CE && REG.read) |=> $stable(RDATA))
    else $error("read data changed without a read");

  a_ctrl_freeze: assert property (
    @(posedge CLK) disable iff (!NRST)
    !CE |=> ($stable(s.ctrl2) && $stable(s.en_fall) && $stable(s.en_rise)))
    else $error("register moved while clock enable low");

  a_latch_freeze: assert property (
    @(posedge CLK) disable iff (!NRST)
    !CE |=> $stable(s.latch))
    else $error("latch moved while clock enable low");

  a_reset_ctrl: assert property (
    @(posedge CLK)
    (!NRST) [*2] |-> (LINE_CTRL == CTRL2_RESET))
    else $error("control register not at power-up value in reset");

  a_reset_regs: assert property (
    @(posedge CLK)
    (!NRST) [*2] |-> (LATCH == LATCH_RESET && RDATA == READ_ZERO))
    else $error("latch or read data not cleared in reset");

  a_latch_sticky: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && !(REG.write && REG.addr == ADDR_LATCH_CLEAR))
    |=> ((s.latch & $past(s.latch)) == $past(s.latch)))
    else $error("latch bit dropped without a clear write");

  a_latch_set: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_LATCH_SET)
    |=> ((s.latch & $past(REG.wdata)) == $past(REG.wdata)))
    else $error("latch set write did not set");

  a_latch_clear: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_LATCH_CLEAR)
    |=> ((s.latch & $past(REG.wdata) & ~$past(rise_hits | fall_hits))
         == READ_ZERO))
    else $error("latch clear write did not clear");

  a_fall_set: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_FALL_SET)
    |=> ((s.en_fall & $past(REG.wdata)) == $past(REG.wdata)))
    else $error("falling enable set write did not set");

  a_rise_clear: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && REG.write && REG.addr == ADDR_RISE_CLEAR)
    |=> ((s.en_rise & $past(REG.wdata)) == READ_ZERO))
    else $error("rising enable clear write did not clear");

  a_fall_latched: assert property (
    @(posedge CLK) disable iff (!NRST)
    (CE && primed && ((~src & s.prev_src & s.en_fall) != READ_ZERO))
    |=> ((s.latch & $past(~src & s.prev_src & s.en_fall))
         == $past(~src & s.prev_src & s.en_fall)))
    else $error("enabled falling edge not latched");

endmodule

// [testbench/reg_host_model.sv]
`timescale 1ns/100ps
// ============================================================
// host side of the register port: one byte per call
module reg_host_model
  import otg_line_regs_pkg::*;
(
  // bus side
  input  wire logic       clk,
  output reg_req_t        req,
  input  wire logic [7:0] rdata
);
  initial req = '0;

  // strobe held over one rising edge, then dropped
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    req = '{write: 1'b1, read: 1'b0, addr: a, wdata: d};
    @(negedge clk);
    req.write = 1'b0;
  endtask

  // data is taken a half cycle after the registering edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    req = '{write: 1'b0, read: 1'b1, addr: a, wdata: 8'h00};
    @(negedge clk);
    req.read = 1'b0;
    d = rdata;
  endtask
endmodule

// [testbench/otg_line_regs_tb.sv]
`timescale 1ns/100ps
module otg_line_regs_tb
  import otg_line_regs_pkg::*;
;
  logic       CLK = 1'b0;
  logic       NRST;
  logic       CE;
  reg_req_t   REG;
  logic [7:0] RDATA;
  logic       RECONNECT_ENABLE;
  logic       SOURCE_SELECT;
  comp_t      COMP;
  ctrl2_t     LINE_CTRL;
  logic [7:0] LATCH;
  int         num_errors = 0;
  int         compares = 0;
  int         cycles = 0;
  logic [7:0] corner [4] = '{8'hE0, 8'hC0, 8'h80, 8'h1F};
  logic [7:0] addrs [4] = '{8'h06, 8'h07, 8'h08, 8'h09};

  always #5 CLK = ~CLK;

  otg_line_regs otg_line_regs_inst (
    .CLK              (CLK),
    .NRST             (NRST),
    .CE               (CE),
    .REG              (REG),
    .RDATA            (RDATA),
    .RECONNECT_ENABLE (RECONNECT_ENABLE),
    .SOURCE_SELECT    (SOURCE_SELECT),
    .COMP             (COMP),
    .LINE_CTRL        (LINE_CTRL),
    .LATCH            (LATCH)
  );

  reg_host_model host (
    .clk   (CLK),
    .req   (REG),
    .rdata (RDATA)
  );

  // ============================================================
  // expectations
  function automatic logic [7:0] ctrl_next(input logic [7:0] cur,
                                           input logic [7:0] a,
                                           input logic [7:0] d);
    logic [7:0] n;
    n = cur;
    if (a == ADDR_CTRL2_SET)
    begin
      n = cur | d;
      // one vbus function at a time, drive first
      if (d[5])
        n[7:5] = 3'b001;
      else if (d[6])
        n[7:5] = 3'b010;
      else if (d[7])
        n[7:5] = 3'b100;
    end
    else if (a == ADDR_CTRL2_CLEAR)
      n = cur & ~d;
    return n;
  endfunction

  function automatic logic [7:0] src_of(input comp_t c, input logic re,
                                        input logic sel);
    return {sel ? c.line_rise_threshold : c.session_end,
            c.reconnect_done & re, c.ident_open, c.minus_line_high_seen,
            c.ident_grounded, c.plus_line_high_seen, c.session_valid,
            c.vbus_valid};
  endfunction

  // ============================================================
  // comparison and verdict
  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    compares++;
    if (seen !== want)
    begin
      num_errors++;
      $display("MISMATCH t=%0t seen %h want %h", $time, seen, want);
    end
  endtask

  task automatic tally_and_finish();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // hang guard, far above the roughly 1500 cycles needed
  always @(posedge CLK)
  begin
    cycles++;
    if (cycles == 8000)
    begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ============================================================
  // main sequence
  initial
  begin
    logic [7:0] exp, a, d, r, ef, er, old, nw;
    NRST = 1'b0;
    CE = 1'b1;
    COMP = '0;
    RECONNECT_ENABLE = 1'b0;
    SOURCE_SELECT = 1'b0;
    void'($urandom(32'h779103D5));
    repeat (20) @(negedge CLK);
    check(LINE_CTRL, 8'h0C);
    check(LATCH, 8'h00);
    NRST = 1'b1;
    exp = 8'h0C;
    for (int i = 0; i < 60; i++)
    begin
      a = (i < 4) ? 8'h06 : addrs[$urandom % 4];
      d = (i < 4) ? corner[i] : 8'($urandom);
      exp = ctrl_next(exp, a, d);
      host.wr(a, d);
      check(LINE_CTRL, exp);
      host.rd(addrs[i % 4], r);
      check(r, (i % 4 == 2) ? src_of(COMP, 1'b0, 1'b0)
                            : (i % 4 == 3) ? 8'h00 : exp);
    end
    for (int i = 0; i < 40; i++)
    begin
      RECONNECT_ENABLE = 1'($urandom);
      SOURCE_SELECT = 1'($urandom);
      COMP = comp_t'(9'($urandom));
      repeat (4) @(negedge CLK);
      host.rd(ADDR_SOURCE, r);
      exp = src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT);
      check(r, exp);
      ef = 8'($urandom);
      er = 8'($urandom);
      host.wr(ADDR_FALL_CLEAR, 8'hFF);
      host.wr(ADDR_RISE_CLEAR, 8'hFF);
      host.wr(ADDR_FALL_SET, ef);
      host.wr(ADDR_RISE_SET, er);
      host.wr(ADDR_LATCH_CLEAR, 8'hFF);
      check(LATCH, 8'h00);
      old = src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT);
      @(negedge CLK);
      COMP = comp_t'(9'($urandom));
      repeat (5) @(negedge CLK);
      nw = src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT);
      exp = (nw & ~old & er) | (~nw & old & ef);
      check(LATCH, exp);
      host.rd(ADDR_RISE_SET, r);
      check(r, er);
      host.rd(ADDR_FALL_CLEAR, r);
      check(r, ef);
      host.wr(ADDR_LATCH_SET, 8'h81);
      check(LATCH, exp | 8'h81);
      host.rd(ADDR_LATCH_CLEAR, r);
      check(r, exp | 8'h81);
    end
    // clock enable low: neither a write nor a condition edge lands
    host.wr(ADDR_CTRL2_CLEAR, 8'hFF);
    host.wr(ADDR_CTRL2_SET, 8'h03);
    host.wr(ADDR_FALL_SET, 8'hFF);
    host.wr(ADDR_RISE_SET, 8'hFF);
    host.wr(ADDR_LATCH_CLEAR, 8'hFF);
    old = src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT);
    CE = 1'b0;
    COMP = ~COMP;
    host.wr(ADDR_CTRL2_SET, 8'h1C);
    repeat (5) @(negedge CLK);
    check(LINE_CTRL, 8'h03);
    check(LATCH, 8'h00);
    CE = 1'b1;
    repeat (5) @(negedge CLK);
    nw = src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT);
    check(LATCH, nw ^ old);
    check(LINE_CTRL, 8'h03);
    // reset in mid-run; edges stay blocked until the synchroniser fills
    NRST = 1'b0;
    repeat (3) @(negedge CLK);
    check(LINE_CTRL, 8'h0C);
    check(LATCH, 8'h00);
    check(RDATA, 8'h00);
    NRST = 1'b1;
    host.wr(ADDR_RISE_SET, 8'hFF);
    repeat (4) @(negedge CLK);
    check(LATCH, 8'h00);
    host.rd(ADDR_SOURCE, r);
    check(r, src_of(COMP, RECONNECT_ENABLE, SOURCE_SELECT));
    host.rd(ADDR_FALL_CLEAR, r);
    check(r, 8'h00);
    tally_and_finish();
  end
endmodule
